// ---- core/sample_fifo_pkg.sv ----
/*
  Constants shared by the sample queue and output register block: register
  offsets, field positions, widths, reset values and the wake state code.
  Assumes an 8-bit register address space behind the serial host port.
*/
`default_nettype none

package sample_fifo_pkg;

  // ----------------------------------------------------------------------
  // Widths and depth
  // ----------------------------------------------------------------------
  localparam int unsigned QUEUE_DEPTH  = 32;
  localparam int unsigned ADDR_BITS    = 5;
  localparam int unsigned INDEX_BITS   = 6;
  localparam int unsigned AXIS_BITS    = 16;
  localparam int unsigned SAMPLE_BITS  = 48;
  localparam int unsigned WRAP_BIT     = 5;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_QUEUE_FLAGS       = 8'h0A;
  localparam logic [7:0] OFS_QUEUE_DRAIN_INDEX = 8'h0B;
  localparam logic [7:0] OFS_QUEUE_FILL_INDEX  = 8'h0C;
  localparam logic [7:0] OFS_X_ACCEL_LOW       = 8'h0D;
  localparam logic [7:0] OFS_X_ACCEL_HIGH      = 8'h0E;
  localparam logic [7:0] OFS_Y_ACCEL_LOW       = 8'h0F;
  localparam logic [7:0] OFS_Y_ACCEL_HIGH      = 8'h10;
  localparam logic [7:0] OFS_Z_ACCEL_LOW       = 8'h11;
  localparam logic [7:0] OFS_Z_ACCEL_HIGH      = 8'h12;

  // ----------------------------------------------------------------------
  // Field positions of the queue flags register
  // ----------------------------------------------------------------------
  localparam int unsigned FLAG_EMPTY_BIT = 0;
  localparam int unsigned FLAG_FULL_BIT  = 1;
  localparam int unsigned FLAG_LEVEL_BIT = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  QUEUE_FLAGS_RESET = 8'h01;
  localparam logic [5:0]  INDEX_RESET       = 6'h00;
  localparam logic [47:0] SAMPLE_RESET      = 48'h0000_0000_0000;
  localparam logic [7:0]  BYTE_ZERO         = 8'h00;

  // ----------------------------------------------------------------------
  // Operating state code in which samples are taken
  // ----------------------------------------------------------------------
  localparam logic [1:0] STATE_WAKE = 2'h1;

  // Six-byte data read tracker, Gray coded from SEQ_IDLE through SEQ_ZL
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_XL   = 3'b001,
    SEQ_XH   = 3'b011,
    SEQ_YL   = 3'b010,
    SEQ_YH   = 3'b110,
    SEQ_ZL   = 3'b111
  } read_seq_t;

endpackage

`default_nettype wire

// ---- core/sample_store.sv ----
/*
  Flip-flop storage for the 32-entry sample queue: one write port and one
  combinational read port, both addressed by a 5-bit index.
  Assumes the caller never writes while the queue is full.
*/
`default_nettype none

module sample_store
  import sample_fifo_pkg::*;
(
  input  wire logic                   clk,     // Block clock
  input  wire logic                   rst_n,   // Synchronous reset, low
  input  wire logic                   we,      // Write strobe
  input  wire logic [ADDR_BITS-1:0]   waddr,   // Write location
  input  wire logic [SAMPLE_BITS-1:0] wdata,   // Sample to store
  input  wire logic [ADDR_BITS-1:0]   raddr,   // Read location
  output logic      [SAMPLE_BITS-1:0] rdata    // Stored sample
);

  logic [SAMPLE_BITS-1:0] mem [QUEUE_DEPTH];

  // ----------------------------------------------------------------------
  // Entry storage
  // ----------------------------------------------------------------------
  // Cleared at reset so a read of an unfilled entry is defined
  genvar g;
  generate
    for (g = 0; g < QUEUE_DEPTH; g++) begin : g_entry
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mem[g] <= SAMPLE_RESET;
        end else if (we && (waddr == ADDR_BITS'(g))) begin
          mem[g] <= wdata;
        end
      end
    end
  endgenerate

  // Read port
  assign rdata = mem[raddr];

endmodule

`default_nettype wire

// ---- core/sample_fifo_and_output_regs.sv ----
/*
  Sample queue and output data registers of the accelerometer: takes each
  complete three-axis sample in the wake state, stores it in the 32-entry queue unless full, or in the
  output registers, keeps only the newest taken inside a transaction, and answers host register reads at 0x0A..0x12.
  Assumes the serial front end gives one-cycle read strobes with an 8-bit
  address, and one-cycle pulses for a recognised START and STOP.
*/
`default_nettype none

// Functional notes
// - Status bits: empty 0, full 1, level 2.
// - Queue flags ignore interrupt enable settings.
// - Status reads 0x01 after reset.
// - Empty and full valid even when disabled.
// - Level flag when fill at or above threshold.
// - Status upper five bits read zero.
// - Six-bit drain index, five address bits.
// - Full and empty from index compare with wrap.
// - Fill index advances on each Z-complete sample stored in the queue.
// - Index registers read-only, upper bits zero, reset zero.
// - Latest samples, six bytes, low byte first.
// - Queue enabled: data reads come from queue.
// - Queue advances only after full six-byte read.
// - No data register updates between START and STOP.
// - Combined queue flag is OR of three flags.
// - New-sample flag set on output write, read clears.
// - Samples taken only in wake state.
module sample_fifo_and_output_regs
  import sample_fifo_pkg::*;
(
  input  wire logic        I_REF_CLK,     // 100 MHz block clock
  input  wire logic        I_RST_N,       // Synchronous reset, low
  input  wire logic [15:0] I_X_SAMPLE,    // X axis result
  input  wire logic [15:0] I_Y_SAMPLE,    // Y axis result
  input  wire logic [15:0] I_Z_SAMPLE,    // Z axis result
  input  wire logic        I_Z_DONE,      // Pulse: Z acquired, sample complete
  input  wire logic [1:0]  I_STATE,       // Operating state code
  input  wire logic        I_QUEUE_EN,    // Queue enable bit
  input  wire logic [5:0]  I_LEVEL_SET,   // Fill level threshold
  input  wire logic        I_XFER_START,  // Pulse: START recognised
  input  wire logic        I_XFER_STOP,   // Pulse: STOP seen
  input  wire logic        I_RD_STB,      // Pulse: host register read
  input  wire logic [7:0]  I_RD_ADDR,     // Register address of the read
  input  wire logic        I_STATUS_RD,   // Pulse: main status register read
  output logic      [7:0]  O_RD_DATA,     // Read answer byte
  output logic             O_RD_VALID,    // Pulse: answer valid
  output logic      [7:0]  O_QUEUE_FLAGS, // Queue flags register image
  output logic             O_QUEUE_FLAG,  // Combined queue flag
  output logic             O_NEW_SAMPLE   // New-sample flag
);

  // ----------------------------------------------------------------------
  // Local signals
  // ----------------------------------------------------------------------
  logic [INDEX_BITS-1:0]  drain_index;
  logic [INDEX_BITS-1:0]  fill_index;
  logic [INDEX_BITS-1:0]  fill_level;
  logic                   queue_empty;
  logic                   queue_full;
  logic                   queue_level_reached;
  logic [7:0]             flag_byte;
  logic [SAMPLE_BITS-1:0] out_sample;
  logic [SAMPLE_BITS-1:0] held_sample;
  logic                   held_valid;
  logic [SAMPLE_BITS-1:0] fresh_sample;
  logic [SAMPLE_BITS-1:0] commit_sample;
  logic [SAMPLE_BITS-1:0] head_sample;
  logic                   in_xfer;
  logic                   frozen;
  logic                   take;
  logic                   commit;
  logic                   push;
  logic                   pop;
  logic                   data_addr;
  logic [2:0]             byte_idx;
  logic [7:0]             next_rd_data;
  read_seq_t              read_seq;
  read_seq_t              next_read_seq;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Byte k of a packed sample, x low byte first
  function automatic logic [7:0] sample_byte(input logic [SAMPLE_BITS-1:0] s,
                                             input logic [2:0]             k);
    logic [7:0] b;
    b = BYTE_ZERO;
    unique case (k)
      3'h0:    b = s[7:0];
      3'h1:    b = s[15:8];
      3'h2:    b = s[23:16];
      3'h3:    b = s[31:24];
      3'h4:    b = s[39:32];
      3'h5:    b = s[47:40];
      default: b = BYTE_ZERO;
    endcase
    return b;
  endfunction

  // Address expected next while walking the six data bytes
  function automatic logic [7:0] expected_addr(input read_seq_t s);
    logic [7:0] a;
    a = OFS_X_ACCEL_LOW;
    unique case (s)
      SEQ_IDLE: a = OFS_X_ACCEL_LOW;
      SEQ_XL:   a = OFS_X_ACCEL_HIGH;
      SEQ_XH:   a = OFS_Y_ACCEL_LOW;
      SEQ_YL:   a = OFS_Y_ACCEL_HIGH;
      SEQ_YH:   a = OFS_Z_ACCEL_LOW;
      SEQ_ZL:   a = OFS_Z_ACCEL_HIGH;
    endcase
    return a;
  endfunction

  // ----------------------------------------------------------------------
  // Queue flags
  // ----------------------------------------------------------------------
  // Pure index compare, so no enable or interrupt setting can mask them
  assign queue_empty = (drain_index == fill_index);
  assign queue_full  = (drain_index[ADDR_BITS-1:0] == fill_index[ADDR_BITS-1:0]) &&
                       (drain_index[WRAP_BIT] != fill_index[WRAP_BIT]);
  assign fill_level  = INDEX_BITS'(fill_index - drain_index);
  assign queue_level_reached = (fill_level >= I_LEVEL_SET);

  // Reserved upper bits tied to zero
  always_comb begin
    flag_byte = BYTE_ZERO;
    flag_byte[FLAG_EMPTY_BIT] = queue_empty;
    flag_byte[FLAG_FULL_BIT]  = queue_full;
    flag_byte[FLAG_LEVEL_BIT] = queue_level_reached;
  end

  // Registered images of the flags for the status logic outside
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_QUEUE_FLAGS <= QUEUE_FLAGS_RESET;
      O_QUEUE_FLAG  <= 1'b1;
    end else begin
      O_QUEUE_FLAGS <= flag_byte;
      O_QUEUE_FLAG  <= queue_empty | queue_full | queue_level_reached;
    end
  end

  // ----------------------------------------------------------------------
  // Sample intake and transaction freeze
  // ----------------------------------------------------------------------
  assign fresh_sample = {I_Z_SAMPLE, I_Y_SAMPLE, I_X_SAMPLE};
  assign take         = I_Z_DONE && (I_STATE == STATE_WAKE);

  // Freeze starts on the START cycle itself so the first byte is stable
  assign frozen       = in_xfer || I_XFER_START;
  assign commit       = !frozen && (take || held_valid);
  assign commit_sample = take ? fresh_sample : held_sample;
  assign push         = commit && I_QUEUE_EN && !queue_full;
  // Transaction window, START given priority over a same-cycle STOP
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      in_xfer <= 1'b0;
    end else if (I_XFER_START) begin
      in_xfer <= 1'b1;
    end else if (I_XFER_STOP) begin
      in_xfer <= 1'b0;
    end
  end

  // One holding slot; newest sample wins so the data is current at STOP
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      held_valid  <= 1'b0;
      held_sample <= SAMPLE_RESET;
    end else if (take && frozen) begin
      held_valid  <= 1'b1;
      held_sample <= fresh_sample;
    end else if (commit) begin
      held_valid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Output data registers
  // ----------------------------------------------------------------------
  // Written only while the queue is off; queue mode stores instead
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      out_sample <= SAMPLE_RESET;
    end else if (commit && !I_QUEUE_EN) begin
      out_sample <= commit_sample;
    end
  end

  // New-sample flag: a set in the clearing cycle is kept
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_NEW_SAMPLE <= 1'b0;
    end else if (commit && !I_QUEUE_EN) begin
      O_NEW_SAMPLE <= 1'b1;
    end else if (I_STATUS_RD) begin
      O_NEW_SAMPLE <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Queue storage and indices
  // ----------------------------------------------------------------------
  sample_store u_store (
    .clk   (I_REF_CLK),
    .rst_n (I_RST_N),
    .we    (push),
    .waddr (fill_index[ADDR_BITS-1:0]),
    .wdata (commit_sample),
    .raddr (drain_index[ADDR_BITS-1:0]),
    .rdata (head_sample)
  );

  // Fill index moves once per stored sample; the wrap bit rides along
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      fill_index <= INDEX_RESET;
    end else if (push) begin
      fill_index <= INDEX_BITS'(fill_index + 1'b1);
    end
  end

  // Drain index moves only on a completed six-byte queue read
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      drain_index <= INDEX_RESET;
    end else if (pop) begin
      drain_index <= INDEX_BITS'(drain_index + 1'b1);
    end
  end

  // ----------------------------------------------------------------------
  // Six-byte read tracker
  // ----------------------------------------------------------------------
  // A read of X low always restarts the walk; any stray read abandons it
  always_comb begin
    next_read_seq = read_seq;
    if (I_RD_STB) begin
      if (I_RD_ADDR == OFS_X_ACCEL_LOW) begin
        next_read_seq = SEQ_XL;
      end else if ((read_seq != SEQ_IDLE) && (I_RD_ADDR == expected_addr(read_seq))) begin
        unique case (read_seq)
          SEQ_XL:   next_read_seq = SEQ_XH;
          SEQ_XH:   next_read_seq = SEQ_YL;
          SEQ_YL:   next_read_seq = SEQ_YH;
          SEQ_YH:   next_read_seq = SEQ_ZL;
          SEQ_ZL:   next_read_seq = SEQ_IDLE;
          SEQ_IDLE: next_read_seq = SEQ_IDLE;
        endcase
      end else begin
        next_read_seq = SEQ_IDLE;
      end
    end
  end

  // Walk only counts in queue mode; a new START begins a fresh walk
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      read_seq <= SEQ_IDLE;
    end else if (I_XFER_START || !I_QUEUE_EN) begin
      read_seq <= SEQ_IDLE;
    end else begin
      read_seq <= next_read_seq;
    end
  end

  // Pop on the Z high byte that closes the walk; empty queue is not moved
  assign pop = I_RD_STB && I_QUEUE_EN && !I_XFER_START && (read_seq == SEQ_ZL) &&
               (I_RD_ADDR == OFS_Z_ACCEL_HIGH) && !queue_empty;

  // ----------------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------------
  assign data_addr = (I_RD_ADDR >= OFS_X_ACCEL_LOW) && (I_RD_ADDR <= OFS_Z_ACCEL_HIGH);
  assign byte_idx  = 3'(I_RD_ADDR - OFS_X_ACCEL_LOW);

  // Unmapped addresses answer zero so the front end can merge answers
  always_comb begin
    next_rd_data = BYTE_ZERO;
    if (I_RD_ADDR == OFS_QUEUE_FLAGS) begin
      next_rd_data = flag_byte;
    end else if (I_RD_ADDR == OFS_QUEUE_DRAIN_INDEX) begin
      next_rd_data = {2'b00, drain_index};
    end else if (I_RD_ADDR == OFS_QUEUE_FILL_INDEX) begin
      next_rd_data = {2'b00, fill_index};
    end else if (data_addr && I_QUEUE_EN) begin
      next_rd_data = sample_byte(head_sample, byte_idx);
    end else if (data_addr) begin
      next_rd_data = sample_byte(out_sample, byte_idx);
    end
  end

  // Answer one cycle after the strobe; data holds until the next read
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_RD_DATA  <= BYTE_ZERO;
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= I_RD_STB;
      if (I_RD_STB) begin
        O_RD_DATA <= next_rd_data;
      end
    end
  end

endmodule

`default_nettype wire

// ---- bench/sample_fifo_checker.sv ----
/*
  Port assertions for the sample queue and output register block.
  Assumes one clock domain and the synchronous low reset of the top module.
*/
`default_nettype none

module sample_fifo_checker
  import sample_fifo_pkg::*;
(
  input wire logic       I_REF_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_Z_DONE,
  input wire logic [1:0] I_STATE,
  input wire logic       I_QUEUE_EN,
  input wire logic       I_XFER_START,
  input wire logic       I_XFER_STOP,
  input wire logic       I_RD_STB,
  input wire logic [7:0] I_RD_ADDR,
  input wire logic       I_STATUS_RD,
  input wire logic [7:0] O_RD_DATA,
  input wire logic       O_RD_VALID,
  input wire logic [7:0] O_QUEUE_FLAGS,
  input wire logic       O_QUEUE_FLAG,
  input wire logic       O_NEW_SAMPLE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic xfer;  // Host transaction open

  // Track START/STOP; START wins a tie, same as the block
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      xfer <= 1'b0;
    end else if (I_XFER_START) begin
      xfer <= 1'b1;
    end else if (I_XFER_STOP) begin
      xfer <= 1'b0;
    end
  end

  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_read(logic [7:0] a);
    I_RD_STB && I_RD_ADDR == a;
  endsequence
  sequence s_sample;
    I_Z_DONE && I_STATE == STATE_WAKE;
  endsequence

  a_reset_flags: assert property ($rose(I_RST_N) |-> O_QUEUE_FLAGS == QUEUE_FLAGS_RESET)
    else $error("queue flags not one after reset");
  a_combined_flag: assert property (O_QUEUE_FLAG == |O_QUEUE_FLAGS[2:0])
    else $error("combined flag differs from OR of flags");
  a_not_full_empty: assert property (!(O_QUEUE_FLAGS[0] && O_QUEUE_FLAGS[1]))
    else $error("queue empty and full together");
  a_status_read_match: assert property (s_read(OFS_QUEUE_FLAGS) |=> O_RD_VALID && O_RD_DATA == O_QUEUE_FLAGS)
    else $error("flags read differs from flags image");
  a_index_upper_zero: assert property (I_RD_STB && (I_RD_ADDR == OFS_QUEUE_DRAIN_INDEX || I_RD_ADDR == OFS_QUEUE_FILL_INDEX)
    |=> O_RD_VALID && O_RD_DATA[7:6] == 2'h0) else $error("index read upper bits set");
  a_sample_sets_new: assert property (s_sample ##0 (!I_QUEUE_EN && !xfer && !I_XFER_START) |=> O_NEW_SAMPLE)
    else $error("new-sample flag not set");
  a_clear_on_read: assert property (I_STATUS_RD && !I_Z_DONE && !$past(xfer) |=> !O_NEW_SAMPLE)
    else $error("new-sample flag not cleared by status read");
  a_wake_only: assert property ($rose(O_NEW_SAMPLE) |-> $past(I_Z_DONE && I_STATE == STATE_WAKE) || $past(xfer, 2))
    else $error("new-sample flag rose without a wake sample");
  a_freeze_new: assert property (xfer && $past(xfer) |-> !$rose(O_NEW_SAMPLE))
    else $error("output data updated inside transaction");
endmodule

bind sample_fifo_and_output_regs sample_fifo_checker sample_fifo_checker_i (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_Z_DONE(I_Z_DONE), .I_STATE(I_STATE),
  .I_QUEUE_EN(I_QUEUE_EN), .I_XFER_START(I_XFER_START), .I_XFER_STOP(I_XFER_STOP),
  .I_RD_STB(I_RD_STB), .I_RD_ADDR(I_RD_ADDR), .I_STATUS_RD(I_STATUS_RD), .O_RD_DATA(O_RD_DATA),
  .O_RD_VALID(O_RD_VALID), .O_QUEUE_FLAGS(O_QUEUE_FLAGS), .O_QUEUE_FLAG(O_QUEUE_FLAG),
  .O_NEW_SAMPLE(O_NEW_SAMPLE));

`default_nettype wire

// ---- bench/reg_host_model.sv ----
/*
  Host model: single register reads and main status reads.
  Assumes the answer arrives one clock after the strobe is taken.
*/
`default_nettype none

module reg_host_model (
  input  wire logic       clk,      // Block clock
  input  wire logic [7:0] rd_data,  // Answer byte
  input  wire logic       rd_valid, // Answer strobe
  output var  logic       rd_stb,   // Read strobe
  output var  logic [7:0] rd_addr,  // Read address
  output var  logic       stat_rd   // Status read pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle host at time zero
  initial begin
    rd_stb = 1'b0;
    rd_addr = 8'h00;
    stat_rd = 1'b0;
  end

  // One read; a missing answer comes back unknown so it never matches
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_stb <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    rd_addr <= ~a;  // Stale address must not look like a request
    #1;
    d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
  endtask

  // Main status read, which clears the new-sample flag
  task automatic stat();
    @(posedge clk);
    stat_rd <= 1'b1;
    @(posedge clk);
    stat_rd <= 1'b0;
    #1;
  endtask
endmodule

`default_nettype wire

// ---- bench/sample_fifo_and_output_regs_tb.sv ----
/*
  Self-checking bench: random samples, direct and queue modes, freeze.
  Assumes the host model in reg_host_model and the bound checker.
*/
`default_nettype none

module sample_fifo_and_output_regs_tb;
  import sample_fifo_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, z_done, q_en, x_start, x_stop, stb, st_rd, valid, qflag, news;
  logic [15:0] xs, ys, zs;
  logic [1:0]  state;
  logic [5:0]  lvl;
  logic [7:0]  addr, rdata, qflags, d;
  logic [31:0] seed = 32'h0001_0CD7;  // 68823
  logic [47:0] smp, old;
  logic [47:0] q[$];
  logic [5:0]  fill_m = 6'h00;
  logic [5:0]  drain_m = 6'h00;
  int          err_count = 0;
  int          checks = 0;

  sample_fifo_and_output_regs sample_fifo_and_output_regs_i (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_X_SAMPLE(xs), .I_Y_SAMPLE(ys), .I_Z_SAMPLE(zs),
    .I_Z_DONE(z_done), .I_STATE(state), .I_QUEUE_EN(q_en), .I_LEVEL_SET(lvl),
    .I_XFER_START(x_start), .I_XFER_STOP(x_stop), .I_RD_STB(stb), .I_RD_ADDR(addr),
    .I_STATUS_RD(st_rd), .O_RD_DATA(rdata), .O_RD_VALID(valid), .O_QUEUE_FLAGS(qflags),
    .O_QUEUE_FLAG(qflag), .O_NEW_SAMPLE(news));
  reg_host_model reg_host_model_i (.clk(clk), .rd_data(rdata), .rd_valid(valid),
    .rd_stb(stb), .rd_addr(addr), .stat_rd(st_rd));

  // ----------------------------------------
  // Expectation helpers
  // ----------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Wrap bit makes a 64-step distance, so 32 apart means full
  function automatic logic [7:0] flags_of(input logic [5:0] f, input logic [5:0] r, input logic [5:0] t);
    logic [5:0] n;
    n = f - r;
    return {5'h00, (n >= t), (n == 6'h20), (n == 6'h00)};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_host_model_i.rd(a, v);
    chk(v, exp);
  endtask
  // Whole six-byte walk, low byte of each axis first
  task automatic rd_six(input logic [47:0] e);
    for (int k = 0; k < 6; k++) begin
      rd_chk(OFS_X_ACCEL_LOW + 8'(k), e[8*k +: 8]);
    end
  endtask
  task automatic push(input logic [1:0] st);
    seed = xorshift(seed);
    smp[31:0] = seed;
    seed = xorshift(seed);
    smp[47:32] = seed[15:0];
    @(posedge clk);
    {zs, ys, xs} <= smp;
    state <= st;
    z_done <= 1'b1;
    @(posedge clk);
    z_done <= 1'b0;
    #1;  // Let the edge's updates settle before any look at outputs
  endtask
  // Queue push with the model kept alongside; full drops the sample
  task automatic push_q();
    push(STATE_WAKE);
    if (q.size() < 32) begin
      q.push_back(smp);
      fill_m++;
    end
  endtask
  task automatic xfer(input logic open);
    @(posedge clk);
    x_start <= open;
    x_stop <= !open;
    @(posedge clk);
    x_start <= 1'b0;
    x_stop <= 1'b0;
  endtask
  task automatic check_flags();
    rd_chk(OFS_QUEUE_FILL_INDEX, {2'h0, fill_m});
    rd_chk(OFS_QUEUE_DRAIN_INDEX, {2'h0, drain_m});
    rd_chk(OFS_QUEUE_FLAGS, flags_of(fill_m, drain_m, lvl));
    chk(qflags, flags_of(fill_m, drain_m, lvl));
    chk({7'h00, qflag}, {7'h00, |flags_of(fill_m, drain_m, lvl)});
  endtask
  task automatic results();
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well past the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, z_done, q_en, x_start, x_stop, xs, ys, zs} = '0;
    state = STATE_WAKE;
    lvl = 6'h10;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(OFS_QUEUE_FLAGS, QUEUE_FLAGS_RESET);
    for (int a = 11; a <= 18; a++) begin
      rd_chk(8'(a), BYTE_ZERO);
    end
    rd_chk(8'h20, BYTE_ZERO);
    // Direct mode: every state code, only wake updates
    old = SAMPLE_RESET;
    for (int s = 0; s < 4; s++) begin
      push(2'(s));
      if (s == 1) begin
        old = smp;
        chk({7'h00, news}, 8'h01);
        reg_host_model_i.stat();
        chk({7'h00, news}, 8'h00);
      end else begin
        chk({7'h00, news}, 8'h00);
      end
      rd_six(old);
    end
    // Freeze: sample inside a transaction lands after STOP
    xfer(1'b1);
    push(STATE_WAKE);
    rd_six(old);
    xfer(1'b0);
    rd_six(smp);
    // Queue mode: fill past full
    @(posedge clk);
    q_en <= 1'b1;
    for (int n = 0; n < 34; n++) begin
      push_q();
      check_flags();
    end
    @(posedge clk);
    q_en <= 1'b0;
    rd_chk(OFS_QUEUE_FLAGS, flags_of(fill_m, drain_m, lvl));
    @(posedge clk);
    q_en <= 1'b1;
    // Broken walk must not pop
    rd_chk(OFS_X_ACCEL_LOW, q[0][7:0]);
    rd_chk(OFS_X_ACCEL_HIGH, q[0][15:8]);
    check_flags();
    // Drain through the wrap, one pop on empty
    for (int n = 0; n < 33; n++) begin
      if (q.size() > 0) begin
        rd_six(q.pop_front());
        drain_m++;
      end else begin
        for (int k = 0; k < 6; k++) begin
          reg_host_model_i.rd(OFS_X_ACCEL_LOW + 8'(k), d);
        end
      end
      check_flags();
    end
    // Random push and pop mix past the wrap
    for (int n = 0; n < 80; n++) begin
      seed = xorshift(seed);
      if (seed[1:0] != 2'h0) begin
        push_q();
      end else if (q.size() > 0) begin
        rd_six(q.pop_front());
        drain_m++;
      end
      check_flags();
    end
    results();
  end
endmodule

`default_nettype wire
